// ===== rtl/uart_flags_pkg.sv
// constants for the serial status and error-flag block
package uart_flags_pkg;
  // register port geometry
  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;
  // register addresses
  localparam logic [ADDR_W-1:0] STATUS_LOW_ADDR = 4'h0;
  localparam logic [ADDR_W-1:0] STATUS_HIGH_ADDR = 4'h4;
  localparam logic [ADDR_W-1:0] IRQ_ENABLE_ADDR = 4'h8;
  localparam logic [ADDR_W-1:0] RX_DATA_ADDR = 4'hc;
  // low status word flag positions; enable register uses the same layout
  localparam int FLAG_W = 6;
  localparam int TXC_BIT = 0;
  localparam int OVF_BIT = 1;
  localparam int BRK_BIT = 2;
  localparam int FRAMING_ERROR_FLAG_BIT = 3;
  localparam int CERR_BIT = 4;
  localparam int ABD_BIT = 5;
  // flags that hardware sets and software clears by writing one
  localparam logic [FLAG_W-1:0] STICKY_MASK = 6'h37;
  localparam logic [FLAG_W-1:0] FLAGS_RESET = 6'h00;
  localparam logic [FLAG_W-1:0] ENABLE_RESET = 6'h00;
  // high status word field positions
  localparam int SEL_W = 3;
  localparam int RXSEL_LSB = 8;
  localparam int TXSEL_LSB = 12;
  localparam int TXBE_BIT = 5;
  localparam int TXBF_BIT = 4;
  localparam int RECEIVE_IDLE_BIT = 3;
  localparam int XON_BIT = 2;
  localparam int RXBE_BIT = 1;
  localparam int RXBF_BIT = 0;
  localparam logic [SEL_W-1:0] SEL_RESET = 3'h0;
  // receive buffer shape
  localparam int CHAR_W = 9;
  localparam int RX_DEPTH = 8;
endpackage : uart_flags_pkg

// ===== rtl/reset_sync.sv
// two-stage release synchroniser for the active-low reset
`timescale 1ns/1ps
`default_nettype none
module reset_sync (
  // clock and raw reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // released reset
  output logic rst_sync_n
);
  typedef struct packed {
    logic stage1;
    logic stage2;
  } sync_s;
  sync_s q;
  sync_s next_q;

  // shift a one in after release; stage1 feeds only stage2
  always_comb begin
    next_q.stage1 = 1'b1;
    next_q.stage2 = q.stage1;
  end

  // assert asynchronously, release on the clock
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  assign rst_sync_n = q.stage2;
endmodule : reset_sync
`default_nettype wire

// ===== rtl/rx_frame_buffer.sv
// receive buffer that stores each character with its stop-bit error
`timescale 1ns/1ps
`default_nettype none
module rx_frame_buffer #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 8
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // filling side
  input wire logic push,
  input wire logic [WIDTH-1:0] push_data,
  input wire logic push_stop,
  // draining side
  input wire logic pop,
  output logic [WIDTH-1:0] head_data,
  output logic head_frame_err,
  output logic empty,
  output logic full
);
  localparam int PTR_W = $clog2(DEPTH);
  typedef struct packed {
    logic [PTR_W-1:0] wr_ptr;
    logic [PTR_W-1:0] rd_ptr;
    logic [PTR_W:0] count;
  } buf_s;
  buf_s q;
  buf_s next_q;
  logic [WIDTH:0] mem [DEPTH];
  logic do_push;
  logic do_pop;

  // a push into a full buffer is dropped; the owner flags the overflow
  always_comb begin
    do_push = push && !full;
    do_pop = pop && !empty;
    next_q = q;
    if (do_push) begin
      next_q.wr_ptr = PTR_W'((q.wr_ptr + 1'b1) % DEPTH);
    end
    if (do_pop) begin
      next_q.rd_ptr = PTR_W'((q.rd_ptr + 1'b1) % DEPTH);
    end
    next_q.count = q.count + (PTR_W+1)'(do_push) - (PTR_W+1)'(do_pop);
  end

  // pointer state
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  // storage: the inverted stop level travels with its character
  always_ff @(posedge sys_clk) begin
    if (do_push) begin
      mem[q.wr_ptr] <= {!push_stop, push_data};
    end
  end

  // head view and fill state
  assign head_data = mem[q.rd_ptr][WIDTH-1:0];
  assign head_frame_err = !empty && mem[q.rd_ptr][WIDTH];
  assign empty = (q.count == '0);
  assign full = (q.count == (PTR_W+1)'(DEPTH));

  property p_frame_follows_char;
    @(posedge sys_clk) disable iff (!rst_n)
    (push && empty && !pop) |=> (head_frame_err == !$past(push_stop));
  endproperty
  a_frame_follows_char: assert property (p_frame_follows_char)
    else $error("framing flag does not match the stored stop bit");
endmodule : rx_frame_buffer
`default_nettype wire

// ===== rtl/uart_status_error_flags.sv
// status and error-flag logic of the serial port with its register port
`timescale 1ns/1ps
`default_nettype none
//
// Contract
// - a baud generator wrap during an auto-baud measurement sets the auto-baud overflow flag, held until software clears it.
// - a failed checksum sets the checksum error flag, held until software clears it.
// - the framing flag is the inverted stop level of the head character and travels through the buffer with it.
// - a received break sets the break flag, held until software clears it.
// - a character arriving into a full receive buffer sets the overflow flag, held until software clears it.
// - each sent word is compared with the word read back and a mismatch sets the collision flag until software clears it.
// - each flag has its own enable and the interrupt rises only for a set flag whose enable is one.
module uart_status_error_flags
  import uart_flags_pkg::*;
#(
  parameter int RX_BUF_DEPTH = uart_flags_pkg::RX_DEPTH
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // register port
  input wire logic [uart_flags_pkg::ADDR_W-1:0] addr,
  input wire logic [uart_flags_pkg::DATA_W-1:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [uart_flags_pkg::DATA_W-1:0] rd_data,
  // auto-baud and checksum events
  input wire logic autobaud_active,
  input wire logic brg_wrap,
  input wire logic checksum_bad,
  // receiver events
  input wire logic break_rx,
  input wire logic rx_char_valid,
  input wire logic [uart_flags_pkg::CHAR_W-1:0] rx_char,
  input wire logic rx_stop_bit,
  // transmit read-back compare
  input wire logic tx_echo_valid,
  input wire logic [uart_flags_pkg::CHAR_W-1:0] tx_word,
  input wire logic [uart_flags_pkg::CHAR_W-1:0] echo_word,
  // transmitter and line state
  input wire logic tx_buffer_empty,
  input wire logic tx_buffer_full,
  input wire logic receive_idle,
  input wire logic flow_resume,
  // interrupt
  output logic irq
);
  import uart_flags_pkg::*;

  typedef struct packed {
    logic [FLAG_W-1:0] flags;
    logic [FLAG_W-1:0] enable;
    logic [SEL_W-1:0] tx_irq_threshold_sel;
    logic [SEL_W-1:0] rx_irq_threshold_sel;
    logic tx_buffer_empty;
    logic tx_buffer_full;
    logic receive_idle;
    logic flow_resume;
    logic [DATA_W-1:0] rd_data;
    logic irq;
  } state_s;

  state_s q;
  state_s next_q;
  logic rst_sync_n;
  logic [CHAR_W-1:0] head_char;
  logic framing_error_flag;
  logic rx_buffer_empty;
  logic rx_buffer_full;
  logic rx_pop;
  logic [FLAG_W-1:0] flag_view;
  logic [FLAG_W-1:0] set_vec;
  logic [FLAG_W-1:0] clr_vec;
  logic [DATA_W-1:0] status_high;

  // reset release
  reset_sync u_reset_sync (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .rst_sync_n(rst_sync_n)
  );

  // receive buffer carrying each character's framing bit
  rx_frame_buffer #(
    .WIDTH(CHAR_W),
    .DEPTH(RX_BUF_DEPTH)
  ) u_rx_buf (
    .sys_clk(sys_clk),
    .rst_n(rst_sync_n),
    .push(rx_char_valid),
    .push_data(rx_char),
    .push_stop(rx_stop_bit),
    .pop(rx_pop),
    .head_data(head_char),
    .head_frame_err(framing_error_flag),
    .empty(rx_buffer_empty),
    .full(rx_buffer_full)
  );

  // reading the data register drains one character
  assign rx_pop = rd_en && (addr == RX_DATA_ADDR) && !rx_buffer_empty;

  // hardware events that set sticky flags
  always_comb begin
    set_vec = '0;
    set_vec[ABD_BIT] = brg_wrap && autobaud_active;
    set_vec[CERR_BIT] = checksum_bad;
    set_vec[BRK_BIT] = break_rx;
    set_vec[OVF_BIT] = rx_char_valid && rx_buffer_full;
    set_vec[TXC_BIT] = tx_echo_valid && (tx_word != echo_word);
  end

  // write-one-to-clear on the low status word, sticky bits only
  always_comb begin
    clr_vec = '0;
    if (wr_en && (addr == STATUS_LOW_ADDR)) begin
      clr_vec = wr_data[FLAG_W-1:0] & STICKY_MASK;
    end
  end

  // readable flag view: framing bit comes from the buffer head
  always_comb begin
    flag_view = q.flags;
    flag_view[FRAMING_ERROR_FLAG_BIT] = framing_error_flag;
  end

  // high status word layout
  always_comb begin
    status_high = '0;
    status_high[TXSEL_LSB +: SEL_W] = q.tx_irq_threshold_sel;
    status_high[RXSEL_LSB +: SEL_W] = q.rx_irq_threshold_sel;
    status_high[TXBE_BIT] = q.tx_buffer_empty;
    status_high[TXBF_BIT] = q.tx_buffer_full;
    status_high[RECEIVE_IDLE_BIT] = q.receive_idle;
    status_high[XON_BIT] = q.flow_resume;
    status_high[RXBE_BIT] = rx_buffer_empty;
    status_high[RXBF_BIT] = rx_buffer_full;
  end

  // next state: flags, enables, selects, line state, read data, irq
  always_comb begin
    next_q = q;
    // a set in the same cycle as a clear wins
    next_q.flags = ((q.flags & ~clr_vec) | set_vec) & STICKY_MASK;
    next_q.tx_buffer_empty = tx_buffer_empty;
    next_q.tx_buffer_full = tx_buffer_full;
    next_q.receive_idle = receive_idle;
    next_q.flow_resume = flow_resume;
    if (wr_en && (addr == IRQ_ENABLE_ADDR)) begin
      next_q.enable = wr_data[FLAG_W-1:0];
    end
    if (wr_en && (addr == STATUS_HIGH_ADDR)) begin
      next_q.tx_irq_threshold_sel = wr_data[TXSEL_LSB +: SEL_W];
      next_q.rx_irq_threshold_sel = wr_data[RXSEL_LSB +: SEL_W];
    end
    next_q.rd_data = '0;
    if (rd_en) begin
      unique case (addr)
        STATUS_LOW_ADDR: next_q.rd_data = DATA_W'(flag_view);
        STATUS_HIGH_ADDR: next_q.rd_data = status_high;
        IRQ_ENABLE_ADDR: next_q.rd_data = DATA_W'(q.enable);
        RX_DATA_ADDR: next_q.rd_data = DATA_W'(head_char);
        default: next_q.rd_data = '0;
      endcase
    end
    next_q.irq = |(flag_view & q.enable);
  end

  // state register; line indicators come up at their idle levels
  always_ff @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      q.flags <= FLAGS_RESET;
      q.enable <= ENABLE_RESET;
      q.tx_irq_threshold_sel <= SEL_RESET;
      q.rx_irq_threshold_sel <= SEL_RESET;
      q.tx_buffer_empty <= 1'b1;
      q.tx_buffer_full <= 1'b0;
      q.receive_idle <= 1'b1;
      q.flow_resume <= 1'b1;
      q.rd_data <= '0;
      q.irq <= 1'b0;
    end else begin
      q <= next_q;
    end
  end

  // outputs straight from the state register
  assign rd_data = q.rd_data;
  assign irq = q.irq;

  property p_abd_set;
    @(posedge sys_clk) disable iff (!rst_sync_n)
    (brg_wrap && autobaud_active) |=> q.flags[ABD_BIT];
  endproperty
  a_abd_set: assert property (p_abd_set)
    else $error("auto-baud overflow flag not set after wrap");

  property p_abd_hold;
    @(posedge sys_clk) disable iff (!rst_sync_n)
    (q.flags[ABD_BIT] && !(wr_en && addr == STATUS_LOW_ADDR
      && wr_data[ABD_BIT])) |=> q.flags[ABD_BIT];
  endproperty
  a_abd_hold: assert property (p_abd_hold)
    else $error("auto-baud overflow flag dropped without a clear");

  property p_cerr_set;
    @(posedge sys_clk) disable iff (!rst_sync_n)
    checksum_bad |=> q.flags[CERR_BIT];
  endproperty
  a_cerr_set: assert property (p_cerr_set)
    else $error("checksum error flag not set");

  property p_brk_clear;
    @(posedge sys_clk) disable iff (!rst_sync_n)
    (!break_rx && wr_en && addr == STATUS_LOW_ADDR && wr_data[BRK_BIT])
      |=> !q.flags[BRK_BIT] ##1 (q.flags[BRK_BIT] == $past(break_rx));
  endproperty
  a_brk_clear: assert property (p_brk_clear)
    else $error("break flag clear or set misbehaves");

  property p_ovf_set;
    @(posedge sys_clk) disable iff (!rst_sync_n)
    (rx_char_valid && rx_buffer_full) |=> q.flags[OVF_BIT];
  endproperty
  a_ovf_set: assert property (p_ovf_set)
    else $error("overflow flag not set on push into full buffer");

  property p_txc_set;
    @(posedge sys_clk) disable iff (!rst_sync_n)
    (tx_echo_valid && tx_word != echo_word) |=> q.flags[TXC_BIT];
  endproperty
  a_txc_set: assert property (p_txc_set)
    else $error("collision flag not set on read-back mismatch");

  property p_irq_gate;
    @(posedge sys_clk) disable iff (!rst_sync_n)
    ##1 (irq == $past(|(flag_view & q.enable)));
  endproperty
  a_irq_gate: assert property (p_irq_gate)
    else $error("interrupt does not follow enabled flags");

  property p_reset_view;
    @(posedge sys_clk) disable iff (!rst_sync_n)
    $rose(rst_sync_n) |-> (status_high == 16'h002e) && !irq;
  endproperty
  a_reset_view: assert property (p_reset_view)
    else $error("high status word wrong after reset");

  property p_abd_needs_measure;
    @(posedge sys_clk) disable iff (!rst_sync_n)
    (!q.flags[ABD_BIT] && !autobaud_active) |=> !q.flags[ABD_BIT];
  endproperty
  a_abd_needs_measure: assert property (p_abd_needs_measure)
    else $error("auto-baud overflow flag set outside a measurement");

  property p_cerr_hold;
    @(posedge sys_clk) disable iff (!rst_sync_n)
    (q.flags[CERR_BIT] && !(wr_en && addr == STATUS_LOW_ADDR
      && wr_data[CERR_BIT])) |=> q.flags[CERR_BIT];
  endproperty
  a_cerr_hold: assert property (p_cerr_hold)
    else $error("checksum error flag dropped without a clear");

  property p_framing_error_flag_empty;
    @(posedge sys_clk) disable iff (!rst_sync_n)
    rx_buffer_empty |-> !framing_error_flag;
  endproperty
  a_framing_error_flag_empty: assert property (p_framing_error_flag_empty)
    else $error("framing flag set with an empty receive buffer");

  property p_brk_set;
    @(posedge sys_clk) disable iff (!rst_sync_n)
    break_rx |=> q.flags[BRK_BIT];
  endproperty
  a_brk_set: assert property (p_brk_set)
    else $error("break flag not set after a break");

  property p_ovf_hold;
    @(posedge sys_clk) disable iff (!rst_sync_n)
    (q.flags[OVF_BIT] && !(wr_en && addr == STATUS_LOW_ADDR
      && wr_data[OVF_BIT])) |=> q.flags[OVF_BIT];
  endproperty
  a_ovf_hold: assert property (p_ovf_hold)
    else $error("overflow flag dropped without a clear");

  property p_txc_only_mismatch;
    @(posedge sys_clk) disable iff (!rst_sync_n)
    (!q.flags[TXC_BIT] && !(tx_echo_valid && tx_word != echo_word))
      |=> !q.flags[TXC_BIT];
  endproperty
  a_txc_only_mismatch: assert property (p_txc_only_mismatch)
    else $error("collision flag set without a read-back mismatch");

  property p_irq_masked;
    @(posedge sys_clk) disable iff (!rst_sync_n)
    (q.enable == '0) |=> !irq;
  endproperty
  a_irq_masked: assert property (p_irq_masked)
    else $error("interrupt raised with every enable off");
endmodule : uart_status_error_flags
`default_nettype wire

// ===== bench/serial_node_model.sv
// behavioural remote node feeding the receiver and the echo path
`timescale 1ns/1ps
`default_nettype none
module serial_node_model
  import uart_flags_pkg::*;
(
  // clock
  input wire logic sys_clk,
  // received characters and line events
  output logic rx_char_valid,
  output logic [uart_flags_pkg::CHAR_W-1:0] rx_char,
  output logic rx_stop_bit,
  output logic break_rx,
  // transmit read-back
  output logic tx_echo_valid,
  output logic [uart_flags_pkg::CHAR_W-1:0] tx_word,
  output logic [uart_flags_pkg::CHAR_W-1:0] echo_word
);
  // quiet line at time zero
  initial begin
    rx_char_valid = 1'b0;
    rx_char = 9'h000;
    rx_stop_bit = 1'b1;
    break_rx = 1'b0;
    tx_echo_valid = 1'b0;
    tx_word = 9'h000;
    echo_word = 9'h000;
  end
  // one character; data inverted once the strobe drops
  task send_char(input logic [8:0] c, input logic stop);
    @(posedge sys_clk);
    rx_char_valid <= 1'b1;
    rx_char <= c;
    rx_stop_bit <= stop;
    @(posedge sys_clk);
    rx_char_valid <= 1'b0;
    rx_char <= ~c;
    rx_stop_bit <= ~stop;
  endtask : send_char
  // break condition seen on the line
  task send_break();
    @(posedge sys_clk);
    break_rx <= 1'b1;
    @(posedge sys_clk);
    break_rx <= 1'b0;
  endtask : send_break
  // sent word with what came back from the line
  task send_echo(input logic [8:0] t, input logic [8:0] e);
    @(posedge sys_clk);
    tx_echo_valid <= 1'b1;
    tx_word <= t;
    echo_word <= e;
    @(posedge sys_clk);
    tx_echo_valid <= 1'b0;
    tx_word <= ~t;
    echo_word <= ~e;
  endtask : send_echo
endmodule : serial_node_model
`default_nettype wire

// ===== bench/uart_status_error_flags_tb.sv
// self-checking bench for the status and error-flag block
`timescale 1ns/1ps
`default_nettype none
module uart_status_error_flags_tb;
  import uart_flags_pkg::*;
  logic sys_clk, rst_n, wr_en, rd_en, irq;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wr_data, rd_data, d;
  logic autobaud_active, brg_wrap, checksum_bad, tx_buffer_full;
  logic tx_buffer_empty, receive_idle, flow_resume;
  logic break_rx, rx_char_valid, rx_stop_bit, tx_echo_valid;
  logic [CHAR_W-1:0] rx_char, tx_word, echo_word;
  int n_mismatch = 0;
  int total_checks = 0;
  int cycles = 0;
  int bit_of[4] = '{ABD_BIT, CERR_BIT, BRK_BIT, TXC_BIT};
  // clock generator
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  uart_status_error_flags dut (.sys_clk, .rst_n, .addr, .wr_data,
    .wr_en, .rd_en, .rd_data, .autobaud_active, .brg_wrap,
    .checksum_bad, .break_rx, .rx_char_valid, .rx_char, .rx_stop_bit,
    .tx_echo_valid, .tx_word, .echo_word, .tx_buffer_empty,
    .tx_buffer_full, .receive_idle, .flow_resume, .irq);
  serial_node_model node (.sys_clk, .rx_char_valid, .rx_char,
    .rx_stop_bit, .break_rx, .tx_echo_valid, .tx_word, .echo_word);
  task final_report();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : final_report
  // hang guard
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 3000) begin
      n_mismatch++;
      $display("[ERR] %0t timeout", $time);
      final_report();
    end
  end
  task chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t word %h expected %h", $time, got, exp);
    end
  endtask : chk
  task chki(input logic exp);
    total_checks++;
    if (irq !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t irq %b expected %b", $time, irq, exp);
    end
  endtask : chki
  task wr(input logic [3:0] a, input logic [15:0] v);
    @(posedge sys_clk);
    wr_en <= 1'b1;
    addr <= a;
    wr_data <= v;
    @(posedge sys_clk);
    wr_en <= 1'b0;
  endtask : wr
  // read strobe then sample the single data cycle
  task rdc(input logic [3:0] a, input logic [15:0] exp);
    @(posedge sys_clk);
    rd_en <= 1'b1;
    addr <= a;
    @(posedge sys_clk);
    rd_en <= 1'b0;
    #1 d = rd_data;
    chk(d, exp);
  endtask : rdc
  task tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : tick
  task fire(input int k);
    case (k)
      0: begin
        @(posedge sys_clk);
        brg_wrap <= 1'b1;
        @(posedge sys_clk);
        brg_wrap <= 1'b0;
      end
      1: begin
        @(posedge sys_clk);
        checksum_bad <= 1'b1;
        @(posedge sys_clk);
        checksum_bad <= 1'b0;
      end
      2: node.send_break();
      default: node.send_echo(9'h0a5, 9'h0a4);
    endcase
  endtask : fire
  task t_regs();
    rdc(STATUS_LOW_ADDR, 16'h0000);
    rdc(STATUS_HIGH_ADDR, 16'h002e);
    rdc(IRQ_ENABLE_ADDR, 16'h0000);
    wr(STATUS_HIGH_ADDR, 16'h7700);
    rdc(STATUS_HIGH_ADDR, 16'h772e);
    wr(STATUS_HIGH_ADDR, 16'h0000);
    {tx_buffer_empty, receive_idle, flow_resume} <= 3'h0;
    tx_buffer_full <= 1'b1;
    rdc(STATUS_HIGH_ADDR, 16'h0012);
    {tx_buffer_empty, receive_idle, flow_resume} <= 3'h7;
    tx_buffer_full <= 1'b0;
    wr(4'h2, 16'hffff);
    rdc(4'h2, 16'h0000);
    $display("test regs done");
  endtask : t_regs
  task t_sticky();
    logic [15:0] m;
    autobaud_active <= 1'b0;
    fire(0);
    node.send_echo(9'h155, 9'h155);
    rdc(STATUS_LOW_ADDR, 16'h0000);
    autobaud_active <= 1'b1;
    for (int k = 0; k < 4; k++) begin
      m = 16'h0001 << bit_of[k];
      fire(k);
      rdc(STATUS_LOW_ADDR, m);
      chki(1'b0);
      wr(STATUS_LOW_ADDR, 16'h0000);
      rdc(STATUS_LOW_ADDR, m);
      wr(STATUS_LOW_ADDR, m);
      rdc(STATUS_LOW_ADDR, 16'h0000);
    end
    autobaud_active <= 1'b0;
    $display("test sticky done");
  endtask : t_sticky
  task t_irq();
    wr(IRQ_ENABLE_ADDR, 16'h0010);
    rdc(IRQ_ENABLE_ADDR, 16'h0010);
    fire(1);
    tick(2);
    chki(1'b1);
    wr(IRQ_ENABLE_ADDR, 16'h0020);
    tick(2);
    chki(1'b0);
    wr(IRQ_ENABLE_ADDR, 16'h0010);
    tick(2);
    chki(1'b1);
    wr(STATUS_LOW_ADDR, 16'h0010);
    tick(2);
    chki(1'b0);
    wr(IRQ_ENABLE_ADDR, 16'h0000);
    $display("test irq done");
  endtask : t_irq
  task t_buf();
    for (int i = 0; i < 9; i++) node.send_char(9'h1f0 ^ 9'(i), i[0]);
    rdc(STATUS_HIGH_ADDR, 16'h002d);
    rdc(STATUS_LOW_ADDR, 16'h000a);
    for (int i = 0; i < 8; i++) begin
      rdc(STATUS_LOW_ADDR, i[0] ? 16'h0002 : 16'h000a);
      rdc(RX_DATA_ADDR, {7'h00, 9'h1f0 ^ 9'(i)});
    end
    rdc(STATUS_LOW_ADDR, 16'h0002);
    rdc(STATUS_HIGH_ADDR, 16'h002e);
    wr(STATUS_LOW_ADDR, 16'h0002);
    rdc(STATUS_LOW_ADDR, 16'h0000);
    $display("test buffer done");
  endtask : t_buf
  // reset, then the scenarios in turn
  initial begin
    rst_n = 1'b0;
    {wr_en, rd_en, brg_wrap, checksum_bad, autobaud_active} = 5'h00;
    addr = 4'h0;
    wr_data = 16'h0000;
    {tx_buffer_empty, receive_idle, flow_resume} = 3'h7;
    tx_buffer_full = 1'b0;
    repeat (3) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge sys_clk);
    t_regs();
    t_sticky();
    t_irq();
    t_buf();
    final_report();
  end
endmodule : uart_status_error_flags_tb
`default_nettype wire
